//--- gfc_gpio_top.v
// Purpose: Two general pins with selectable status outputs, button input,
//          plain output, and two divided clock outputs, behind APB
// Assumes: All status inputs are on clk; pin inputs are asynchronous
// Notes: Zero-wait APB slave; read data is captured in the setup cycle
//
// Function
// - Short-circuit codes drive pin with short status
// - Code 61h drives speaker shutdown status
// - Input level field returns de-bounced pin level
// - Input level read ignores polarity bit
// - De-bounced edge may trigger sequencer, edge selectable
// - Both input edges latch sticky interrupt event
// - Output function drives the level bit
// - Output level bit is write only
// - Polarity bit set inverts the driven output
// - Codes 02h/03h show requests; first on pin
// - Every interrupt source has its own mask
// - Codes 35h-3Ch output processor flags one-eight
// - Codes 46h/47h output core RAM-ready status
// - Rising flag or RAM-ready edge latches event
// - Codes 04h/3Dh output divided system/async clocks
// - Clock output runs only while bit15 set
// - System divider bits 7:3, 0 and 1 divide one
// - Async divider uses the same encoding
// - Source select 000-011 picks four frequencies
`timescale 1ns/1ps
`include "gfc_consts.vh"

module gfc_gpio_top #(
  parameter NPIN = 2,
  parameter DEB_CYCLES = 16
) (
  input wire clk, // 40 MHz system clock
  input wire rst_n, // Synchronous reset, active low
  input wire [13:0] paddr, // APB byte address
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, 1 = write
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire [NPIN-1:0] pin_in, // Pin input level
  output reg [NPIN-1:0] pin_out, // Pin output level
  output reg [NPIN-1:0] pin_oe, // Pin output enable, high drives
  output reg irq_req_n, // Dedicated request pin, active low
  output reg [NPIN-1:0] seq_trig, // Sequencer start pulse per pin
  input wire left_headphone_short, // Left headphone positive short
  input wire right_headphone_short, // Right headphone positive short
  input wire speaker_short, // Speaker short detected
  input wire speaker_shutdown, // Speaker shut down
  input wire [7:0] processor_status_flag, // Processor flags one to eight
  input wire [1:0] ram_ready, // RAM ready, second and third cores
  input wire [3:0] sys_src_tick, // Half-period ticks of system sources
  input wire [3:0] async_src_tick // Half-period ticks of async sources
);

  // Filter limit is cut to the counter width on purpose; longer windows wrap
  localparam [31:0] DEB_LIM = DEB_CYCLES - 1;
  localparam [15:0] DEB_MAX = DEB_LIM[15:0];

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg [15:0] pin_cfg_r [0:NPIN-1];
  reg [15:0] ck_cfg_r [0:1];
  reg [`GFC_IRQ_W-1:0] irq_sts_r;
  reg [`GFC_IRQ_W-1:0] mask1_r;
  reg [`GFC_IRQ_W-1:0] mask2_r;
  reg [NPIN-1:0] sync1_r;
  reg [NPIN-1:0] sync2_r;
  reg [NPIN-1:0] deb_lvl_r;
  reg [NPIN-1:0] deb_prev_r;
  reg [7:0] flag_prev_r;
  reg [1:0] ram_prev_r;
  reg [1:0] ck_out_r;
  wire [NPIN-1:0] pin_edge;
  wire first_interrupt_request;
  wire second_interrupt_request;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  // Only word indices decode; the two byte-lane bits are ignored
  wire [11:0] idx = paddr[13:2];
  wire wr_go = psel & penable & pwrite;
  // Read data is loaded in setup, so the access phase never has to wait
  wire rd_setup = psel & ~penable;

  // Register index decode, used for both read and write
  function is_mapped;
    input [11:0] i;
    begin
      is_mapped = (i == `GFC_IDX_PIN0_CFG) || (i == `GFC_IDX_PIN1_CFG) ||
                  (i == `GFC_IDX_IRQ_STS) || (i == `GFC_IDX_IRQ_MASK1) ||
                  (i == `GFC_IDX_IRQ_MASK2) || (i == `GFC_IDX_SYS_CLKOUT) ||
                  (i == `GFC_IDX_ASYNC_CLKOUT);
    end
  endfunction

  // No wait states: the access phase always completes
  assign pready = psel & penable;

  ////////////////////////////////////////////////////////////////////////
  // Read data: captured in setup so prdata comes from a flip-flop
  reg [31:0] rd_nxt;
  integer k;
  always @* begin
    rd_nxt = 32'h0000_0000;
    for (k = 0; k < NPIN; k = k + 1) begin
      if (idx == `GFC_IDX_PIN0_CFG + k) begin
        rd_nxt[15:0] = pin_cfg_r[k];
        // Level field shows the filtered pin on an input, zero on an output, never the stored bit
        rd_nxt[`GFC_LVL_BIT] = pin_cfg_r[k][`GFC_DIR_IN_BIT] & deb_lvl_r[k];
      end
    end
    case (idx)
      `GFC_IDX_IRQ_STS: rd_nxt[`GFC_IRQ_W-1:0] = irq_sts_r;
      `GFC_IDX_IRQ_MASK1: rd_nxt[`GFC_IRQ_W-1:0] = mask1_r;
      `GFC_IDX_IRQ_MASK2: rd_nxt[`GFC_IRQ_W-1:0] = mask2_r;
      `GFC_IDX_SYS_CLKOUT: rd_nxt[15:0] = ck_cfg_r[0];
      `GFC_IDX_ASYNC_CLKOUT: rd_nxt[15:0] = ck_cfg_r[1];
      default: rd_nxt = rd_nxt;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= ~is_mapped(idx);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register writes; reserved bits are dropped so they read zero
  always @(posedge clk) begin
    if (!rst_n) begin
      mask1_r <= `GFC_MASK_RST;
      mask2_r <= `GFC_MASK_RST;
      ck_cfg_r[0] <= `GFC_CK_CFG_RST;
      ck_cfg_r[1] <= `GFC_CK_CFG_RST;
    end else if (wr_go) begin
      case (idx)
        `GFC_IDX_IRQ_MASK1: mask1_r <= pwdata[`GFC_IRQ_W-1:0];
        `GFC_IDX_IRQ_MASK2: mask2_r <= pwdata[`GFC_IRQ_W-1:0];
        `GFC_IDX_SYS_CLKOUT: ck_cfg_r[0] <= pwdata[15:0] & `GFC_CK_CFG_MASK;
        `GFC_IDX_ASYNC_CLKOUT: ck_cfg_r[1] <= pwdata[15:0] & `GFC_CK_CFG_MASK;
        default: mask1_r <= mask1_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky events: a new event in the clearing cycle survives
  wire [`GFC_IRQ_W-1:0] irq_set;
  wire [`GFC_IRQ_W-1:0] irq_clr;
  assign irq_set[`GFC_IRQ_PIN_LO +: NPIN] = pin_edge;
  assign irq_set[`GFC_IRQ_DSP_LO +: 8] = processor_status_flag & ~flag_prev_r;
  assign irq_set[`GFC_IRQ_RAM_LO +: 2] = ram_ready & ~ram_prev_r;
  // Writing a one clears that bit; zero bits leave the status alone
  assign irq_clr = (wr_go && idx == `GFC_IDX_IRQ_STS) ?
                   pwdata[`GFC_IRQ_W-1:0] : {`GFC_IRQ_W{1'b0}};

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_sts_r <= `GFC_IRQ_RST;
      // History starts low: a flag already high at release counts once
      flag_prev_r <= 8'h00;
      ram_prev_r <= 2'b00;
    end else begin
      irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_set;
      flag_prev_r <= processor_status_flag;
      ram_prev_r <= ram_ready;
    end
  end

  // A mask bit of one keeps its event off the request line
  assign first_interrupt_request = |(irq_sts_r & ~mask1_r);
  assign second_interrupt_request = |(irq_sts_r & ~mask2_r);

  // The first request always reaches the dedicated pin
  always @(posedge clk) begin
    if (!rst_n)
      irq_req_n <= 1'b1;
    else
      irq_req_n <= ~first_interrupt_request;
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock outputs: divide half-period ticks of the chosen source
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ck
      reg [4:0] cnt_r;
      // Changing divider or source while running may give one odd period
      wire ena = ck_cfg_r[c][`GFC_CK_ENA_BIT];
      wire [4:0] div = ck_cfg_r[c][`GFC_CK_DIV_HI:`GFC_CK_DIV_LO];
      wire [`GFC_SEL_W-1:0] sel = ck_cfg_r[c][`GFC_CK_SEL_HI:`GFC_CK_SEL_LO];
      wire [3:0] ticks = (c == 0) ? sys_src_tick : async_src_tick;
      // Reserved source codes give no ticks, so the output holds its current level
      wire tick = (sel <= `GFC_SEL_MAX) ? ticks[sel[1:0]] : 1'b0;
      // Codes zero and one both divide by one
      wire [4:0] lim = (div <= `GFC_DIV_ONE) ? 5'h00 : div - `GFC_DIV_ONE;
      // Toggling every n half-periods gives source/n, odd n included
      always @(posedge clk) begin
        if (!rst_n || !ena) begin
          cnt_r <= 5'h00;
          ck_out_r[c] <= 1'b0;
        end else if (tick) begin
          if (cnt_r >= lim) begin
            cnt_r <= 5'h00;
            ck_out_r[c] <= ~ck_out_r[c];
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin function selection, shared by both pins
  function fn_sig;
    input [6:0] fn;
    input lvl;
    input [1:0] irqs;
    input [1:0] cks;
    input [3:0] shorts;
    input [7:0] flags;
    input [1:0] rams;
    begin
      case (fn)
        `GFC_FN_GPIO: fn_sig = lvl;
        `GFC_FN_FIRST_INTERRUPT_REQUEST: fn_sig = irqs[0];
        `GFC_FN_SECOND_INTERRUPT_REQUEST: fn_sig = irqs[1];
        `GFC_FN_MAIN_SYSTEM_CLOCK: fn_sig = cks[0];
        `GFC_FN_SECONDARY_ASYNC_CLOCK: fn_sig = cks[1];
        `GFC_FN_RAM2: fn_sig = rams[0];
        `GFC_FN_RAM3: fn_sig = rams[1];
        `GFC_FN_HPL_SHORT: fn_sig = shorts[0];
        `GFC_FN_HPR_SHORT: fn_sig = shorts[1];
        `GFC_FN_SPK_SHORT: fn_sig = shorts[2];
        `GFC_FN_SPK_SHUT: fn_sig = shorts[3];
        default: begin
          if (fn >= `GFC_FN_DSP_FIRST && fn <= `GFC_FN_DSP_LAST)
            fn_sig = flags[fn[2:0] - 3'h5];
          else
            fn_sig = 1'b0;
        end
      endcase
    end
  endfunction

  // Status inputs come from logic on clk, so they need no synchroniser
  wire [3:0] stat_vec = {speaker_shutdown, speaker_short,
                         right_headphone_short, left_headphone_short};

  ////////////////////////////////////////////////////////////////////////
  // Per-pin logic: sync, filter, edges, config register, driver
  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1) begin : g_pin
      reg [15:0] deb_cnt_r;
      wire [15:0] cfg = pin_cfg_r[p];
      wire deb_en = cfg[`GFC_DEB_EN_BIT];
      wire is_in = cfg[`GFC_DIR_IN_BIT];
      wire rise = deb_lvl_r[p] & ~deb_prev_r[p];
      wire fall = ~deb_lvl_r[p] & deb_prev_r[p];
      wire sel_sig = fn_sig(cfg[`GFC_FN_HI:`GFC_FN_LO], cfg[`GFC_LVL_BIT],
                            {second_interrupt_request, first_interrupt_request}, ck_out_r, stat_vec,
                            processor_status_flag, ram_ready);

      // An output pin reads its own drive back, so its edges are ignored
      assign pin_edge[p] = is_in & (rise | fall);

      // Config write; stored level bit only matters as an output
      always @(posedge clk) begin
        if (!rst_n)
          pin_cfg_r[p] <= `GFC_PIN_CFG_RST;
        else if (wr_go && idx == `GFC_IDX_PIN0_CFG + p)
          pin_cfg_r[p] <= pwdata[15:0] & `GFC_PIN_CFG_MASK;
      end

      // Two stages before anything reads the pin
      // Reset low matches an idle button, so no false edge follows release
      always @(posedge clk) begin
        if (!rst_n) begin
          sync1_r[p] <= 1'b0;
          sync2_r[p] <= 1'b0;
        end else begin
          sync1_r[p] <= pin_in[p];
          sync2_r[p] <= sync1_r[p];
        end
      end

      // Filter: a new level must hold for the whole window when enabled
      always @(posedge clk) begin
        if (!rst_n) begin
          deb_cnt_r <= 16'h0000;
          deb_lvl_r[p] <= 1'b0;
          deb_prev_r[p] <= 1'b0;
        end else begin
          deb_prev_r[p] <= deb_lvl_r[p];
          if (!deb_en || sync2_r[p] == deb_lvl_r[p]) begin
            deb_cnt_r <= 16'h0000;
            deb_lvl_r[p] <= sync2_r[p];
          end else if (deb_cnt_r >= DEB_MAX) begin
            deb_cnt_r <= 16'h0000;
            deb_lvl_r[p] <= sync2_r[p];
          end else begin
            deb_cnt_r <= deb_cnt_r + 16'h0001;
          end
        end
      end

      // Sequencer start on the chosen edge, only in input mode
      always @(posedge clk) begin
        if (!rst_n)
          seq_trig[p] <= 1'b0;
        else
          seq_trig[p] <= is_in & cfg[`GFC_SEQ_EN_BIT] &
                         (cfg[`GFC_SEQ_FALL_BIT] ? fall : rise);
      end

      // Output driver; registered so the pin never glitches on decode
      // An input pin holds its level low with the enable off, so nothing fights
      always @(posedge clk) begin
        if (!rst_n) begin
          pin_out[p] <= 1'b0;
          pin_oe[p] <= 1'b0;
        end else begin
          pin_out[p] <= ~is_in & (sel_sig ^ cfg[`GFC_POL_BIT]);
          pin_oe[p] <= ~is_in;
        end
      end
    end
  endgenerate

endmodule

//--- gfc_consts.vh
// Purpose: Shared constants of the general pin function and clock-out block
// Assumes: 32-bit APB, word registers, byte address = 4 * register index
// Notes: Definitions only
`ifndef GFC_CONSTS_VH
`define GFC_CONSTS_VH

// Register indices (byte address is four times the index)
`define GFC_IDX_PIN0_CFG 12'h0100
`define GFC_IDX_PIN1_CFG 12'h0101
`define GFC_IDX_IRQ_STS 12'h0110
`define GFC_IDX_IRQ_MASK1 12'h0111
`define GFC_IDX_IRQ_MASK2 12'h0112
`define GFC_IDX_SYS_CLKOUT 12'h0149
`define GFC_IDX_ASYNC_CLKOUT 12'h014A

// Pin configuration fields
`define GFC_FN_HI 6
`define GFC_FN_LO 0
`define GFC_SEQ_EN_BIT 10
`define GFC_SEQ_FALL_BIT 11
`define GFC_DEB_EN_BIT 12
`define GFC_LVL_BIT 13
`define GFC_POL_BIT 14
`define GFC_DIR_IN_BIT 15
`define GFC_PIN_CFG_MASK 16'hFC7F
`define GFC_PIN_CFG_RST 16'h8001

// Clock output control fields
`define GFC_CK_ENA_BIT 15
`define GFC_CK_DIV_HI 7
`define GFC_CK_DIV_LO 3
`define GFC_CK_SEL_HI 2
`define GFC_CK_SEL_LO 0
`define GFC_CK_CFG_MASK 16'h80FF
`define GFC_CK_CFG_RST 16'h0000

// Interrupt status layout
`define GFC_IRQ_W 12
`define GFC_IRQ_PIN_LO 0
`define GFC_IRQ_DSP_LO 2
`define GFC_IRQ_RAM_LO 10
`define GFC_IRQ_RST 12'h000
`define GFC_MASK_RST 12'hFFF

// Pin function codes
`define GFC_FN_GPIO 7'h01
`define GFC_FN_FIRST_INTERRUPT_REQUEST 7'h02
`define GFC_FN_SECOND_INTERRUPT_REQUEST 7'h03
`define GFC_FN_MAIN_SYSTEM_CLOCK 7'h04
`define GFC_FN_DSP_FIRST 7'h35
`define GFC_FN_DSP_LAST 7'h3C
`define GFC_FN_SECONDARY_ASYNC_CLOCK 7'h3D
`define GFC_FN_RAM2 7'h46
`define GFC_FN_RAM3 7'h47
`define GFC_FN_HPL_SHORT 7'h55
`define GFC_FN_HPR_SHORT 7'h56
`define GFC_FN_SPK_SHORT 7'h5F
`define GFC_FN_SPK_SHUT 7'h61

// Divider encoding and source codes
`define GFC_DIV_ONE 5'h01
`define GFC_SEL_MAX 3'h3
`define GFC_SEL_W 3

`endif

//--- gfc_gpio_monitor.sv
// Purpose: Port checker for the general pin and clock-out block
// Assumes: Zero-wait APB; pin 0 steering is shadowed from bus writes
// Notes: Bound to the top module below
`timescale 1ns/1ps
`include "gfc_consts.vh"
module gfc_gpio_monitor (
  input wire clk, // Clock
  input wire rst_n, // Reset, active low
  input wire [13:0] paddr, // Address
  input wire psel, // Select
  input wire penable, // Access phase
  input wire pwrite, // Direction
  input wire [31:0] pwdata, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire [1:0] pin_out, // Drive level
  input wire [1:0] pin_oe, // Drive enable
  input wire irq_req_n, // Request pin
  input wire [1:0] seq_trig, // Sequencer pulse
  input wire left_headphone_short, // Left short
  input wire right_headphone_short, // Right short
  input wire speaker_short, // Speaker short
  input wire speaker_shutdown, // Speaker shut down
  input wire [7:0] processor_status_flag, // Flags one to eight
  input wire [1:0] ram_ready // Core RAM ready
);
  wire [11:0] idx = paddr[13:2];
  wire wr = psel && penable && pwrite;
  wire setup = psel && !penable;
  wire mapped = idx == `GFC_IDX_PIN0_CFG || idx == `GFC_IDX_PIN1_CFG ||
    idx == `GFC_IDX_IRQ_STS || idx == `GFC_IDX_IRQ_MASK1 || idx == `GFC_IDX_IRQ_MASK2 ||
    idx == `GFC_IDX_SYS_CLKOUT || idx == `GFC_IDX_ASYNC_CLKOUT;
  reg [15:0] cfg0_r;
  reg [11:0] msk_r;
  reg ena_r;
  reg sel_c;
  wire out_m = !cfg0_r[15];
  wire sel_ok = out_m && ((cfg0_r[6:0] >= 7'h35 && cfg0_r[6:0] <= 7'h3C) ||
    cfg0_r[6:0] == 7'h01 || cfg0_r[6:0] == 7'h55 || cfg0_r[6:0] == 7'h56 ||
    cfg0_r[6:0] == 7'h5F || cfg0_r[6:0] == 7'h61 || cfg0_r[6:0] == 7'h46 ||
    cfg0_r[6:0] == 7'h47);
  //////////////////////////////////////////
  // Shadow registers; a write lands at the access edge, as the slave does
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg0_r <= `GFC_PIN_CFG_RST;
      msk_r <= `GFC_MASK_RST;
      ena_r <= 1'b0;
    end else if (wr) begin
      if (idx == `GFC_IDX_PIN0_CFG) cfg0_r <= pwdata[15:0] & `GFC_PIN_CFG_MASK;
      if (idx == `GFC_IDX_IRQ_MASK1) msk_r <= pwdata[11:0];
      if (idx == `GFC_IDX_SYS_CLKOUT) ena_r <= pwdata[15];
    end
  end
  // Signal pin 0 should show; flag codes wrap their low three bits
  always @* begin
    case (cfg0_r[6:0])
      7'h01: sel_c = cfg0_r[13];
      7'h55: sel_c = left_headphone_short;
      7'h56: sel_c = right_headphone_short;
      7'h5F: sel_c = speaker_short;
      7'h61: sel_c = speaker_shutdown;
      7'h46: sel_c = ram_ready[0];
      7'h47: sel_c = ram_ready[1];
      default: sel_c = processor_status_flag[cfg0_r[2:0] - 3'd5];
    endcase
  end
  //////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_reset_idle: assert property (disable iff (1'b0) !rst_n |=> irq_req_n && pin_oe == 2'b00
    && seq_trig == 2'b00 && !pslverr && prdata == 32'h0) else $error("reset state wrong");
  chk_input_quiet: assert property (pin_oe == 2'b00 |-> pin_out == 2'b00)
    else $error("undriven pin shows a level");
  chk_map_ok: assert property (setup && mapped |=> !pslverr && pready)
    else $error("mapped access refused");
  chk_unmap_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_write_rdzero: assert property (setup && pwrite |=> prdata == 32'h0)
    else $error("write returned data");
  chk_oe_follow: assert property (wr && idx == `GFC_IDX_PIN0_CFG |-> ##2
    pin_oe[0] == !$past(pwdata[15], 2)) else $error("drive enable ignores direction");
  chk_route_sig: assert property (sel_ok ##1 $stable(cfg0_r) |->
    pin_out[0] == ($past(sel_c) ^ cfg0_r[14])) else $error("pin shows wrong signal");
  chk_mask_quiet: assert property (msk_r == 12'hFFF [*2] |-> irq_req_n)
    else $error("masked event raised request");
  chk_clk_gated: assert property ((out_m && cfg0_r[6:0] == 7'h04 && !ena_r && $stable(cfg0_r))
    [*3] |-> pin_out[0] == cfg0_r[14]) else $error("disabled clock output moves");
  cover property (seq_trig[0]);
  cover property (!irq_req_n);
  cover property (out_m && cfg0_r[6:0] == 7'h04 && ena_r && $changed(pin_out[0]));
endmodule
bind gfc_gpio_top gfc_gpio_monitor gfc_gpio_monitor_i (.clk(clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .irq_req_n(irq_req_n), .seq_trig(seq_trig), .left_headphone_short(left_headphone_short),
  .right_headphone_short(right_headphone_short), .speaker_short(speaker_short),
  .speaker_shutdown(speaker_shutdown), .processor_status_flag(processor_status_flag),
  .ram_ready(ram_ready));

//--- gfc_pad_model.sv
// Purpose: Pad and button model on the far side of the two pins
// Assumes: A pin the block drives reads back at its driven level
// Notes: Undriven pins follow the button contacts
`timescale 1ns/1ps
module gfc_pad_model (
  input wire [1:0] pin_out, // Block drive level
  input wire [1:0] pin_oe, // Block drive enable
  input wire [1:0] btn, // Button contact, 1 pressed
  output wire [1:0] pin_in // Level seen at the pins
);
  // The block wins while it drives, so a button cannot fight an output
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & btn);
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the general pin and clock-out block
// Assumes: Zero-wait APB; debounce shortened to two cycles
// Notes: Expected register words live in an associative model
`timescale 1ns/1ps
`include "gfc_consts.vh"
module testbench;
  reg clk = 0;
  reg rst_n = 0;
  reg [13:0] paddr = 0;
  reg psel = 0, penable = 0, pwrite = 0, tick_on = 0, er;
  reg [31:0] pwdata = 0, rd, rv, rnd;
  reg [3:0] shrt = 0, stk = 0, atk = 0;
  reg [7:0] flg = 0;
  reg [1:0] ram = 0, btn = 0, po_q = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq_req_n;
  wire [1:0] pin_in, pin_out, pin_oe, seq_trig;
  integer num_errors = 0, cmp_count = 0, tk0, tk1, tg0, tg1, ns0 = 0, s0 = 0, s1 = 0, i, c;
  int mdl [int];
  int fq [$] = '{'h55, 'h56, 'h5F, 'h61, 'h46, 'h47};
  always #12.5 clk = ~clk;
  gfc_gpio_top #(.NPIN(2), .DEB_CYCLES(2)) gfc_gpio_top_i (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_req_n(irq_req_n), .seq_trig(seq_trig),
    .left_headphone_short(shrt[0]), .right_headphone_short(shrt[1]), .speaker_short(shrt[2]),
    .speaker_shutdown(shrt[3]), .processor_status_flag(flg), .ram_ready(ram),
    .sys_src_tick(stk), .async_src_tick(atk));
  gfc_pad_model gfc_pad_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .btn(btn), .pin_in(pin_in));
  //////////////////////////////////////////
  // Random source ticks; counted here as the dividers should see them
  always @(posedge clk) begin
    rnd = $urandom;
    stk <= tick_on ? rnd[3:0] : 4'h0;
    atk <= tick_on ? rnd[7:4] : 4'h0;
    tk0 = tk0 + (tick_on & rnd[s0]);
    tk1 = tk1 + (tick_on & rnd[4 + s1]);
    if (rst_n) begin
      tg0 = tg0 + (pin_out[0] ^ po_q[0]);
      tg1 = tg1 + (pin_out[1] ^ po_q[1]);
      ns0 = ns0 + seq_trig[0];
    end
    po_q <= pin_out;
  end
  task final_report;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [32:0] got, input [32:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input w, input [11:0] idx, input [31:0] wd);
    integer n;
    begin
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 50) begin
        num_errors = num_errors + 1;
        final_report;
      end
    end
  endtask
  task rchk(input [11:0] idx, input [31:0] exp);
    begin
      apb(0, idx, 32'h0);
      chk({er, rd}, {1'b0, exp});
    end
  endtask
  function sel_exp(input integer c);
    case (c)
      'h55: sel_exp = shrt[0];
      'h56: sel_exp = shrt[1];
      'h5F: sel_exp = shrt[2];
      'h61: sel_exp = shrt[3];
      'h46: sel_exp = ram[0];
      'h47: sel_exp = ram[1];
      default: sel_exp = flg[c - 'h35];
    endcase
  endfunction
  //////////////////////////////////////////
  initial begin
    rnd = $urandom(80785);
    repeat (3) @(posedge clk);
    rst_n <= 1;
    mdl[`GFC_IDX_PIN0_CFG] = 'h8001;
    mdl[`GFC_IDX_PIN1_CFG] = 'h8001;
    mdl[`GFC_IDX_IRQ_STS] = 0;
    mdl[`GFC_IDX_IRQ_MASK1] = 'hFFF;
    mdl[`GFC_IDX_IRQ_MASK2] = 'hFFF;
    mdl[`GFC_IDX_SYS_CLKOUT] = 0;
    mdl[`GFC_IDX_ASYNC_CLKOUT] = 0;
    foreach (mdl[k]) rchk(k[11:0], mdl[k]);
    apb(1, 12'h0FF, 32'hFFFF);
    apb(0, 12'h0FF, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    for (i = 0; i < 2; i = i + 1) begin
      rv = $urandom & 32'h7FFF;
      apb(1, i ? `GFC_IDX_ASYNC_CLKOUT : `GFC_IDX_SYS_CLKOUT, rv);
      rchk(i ? `GFC_IDX_ASYNC_CLKOUT : `GFC_IDX_SYS_CLKOUT, rv & 32'h00FF);
    end
    // Button press and release with debounce and sequencer start
    apb(1, `GFC_IDX_PIN0_CFG, 32'h9401);
    btn <= 2'b01;
    repeat (12) @(posedge clk);
    rchk(`GFC_IDX_PIN0_CFG, 32'hB401);
    apb(1, `GFC_IDX_PIN0_CFG, 32'hDC01);
    rchk(`GFC_IDX_PIN0_CFG, 32'hFC01);
    btn <= 2'b00;
    repeat (12) @(posedge clk);
    rchk(`GFC_IDX_PIN0_CFG, 32'hDC01);
    chk(ns0, 2);
    rchk(`GFC_IDX_IRQ_STS, 32'h1);
    apb(1, `GFC_IDX_IRQ_MASK1, 32'hFFE);
    apb(1, `GFC_IDX_PIN1_CFG, 32'h0002);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_req_n, pin_out[1]}, 33'h1);
    apb(1, `GFC_IDX_IRQ_STS, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_req_n, pin_out[1]}, 33'h2);
    // Plain output: level bit drives the pin, reads back as zero
    apb(1, `GFC_IDX_PIN0_CFG, 32'h2001);
    rchk(`GFC_IDX_PIN0_CFG, 32'h0001);
    chk({31'h0, pin_oe[0], pin_out[0]}, 33'h3);
    apb(1, `GFC_IDX_PIN0_CFG, 32'h6001);
    repeat (3) @(posedge clk);
    chk({31'h0, pin_oe[0], pin_out[0]}, 33'h2);
    // Every status code, random sources and polarity
    for (i = 0; i < 14; i = i + 1) begin
      c = i < 8 ? 'h35 + i : fq[i - 8];
      rv = $urandom;
      shrt <= rv[3:0];
      flg <= rv[11:4];
      ram <= rv[13:12];
      apb(1, `GFC_IDX_PIN0_CFG, {17'h0, rv[14], 7'h0, c[6:0]});
      repeat (3) @(posedge clk);
      chk({32'h0, pin_out[0]}, {32'h0, sel_exp(c) ^ rv[14]});
    end
    flg <= 0;
    ram <= 0;
    repeat (3) @(posedge clk);
    apb(1, `GFC_IDX_IRQ_STS, 32'hFFF);
    rv = $urandom;
    flg <= rv[7:0];
    ram <= rv[9:8];
    repeat (3) @(posedge clk);
    rchk(`GFC_IDX_IRQ_STS, {20'h0, rv[9:8], rv[7:0], 2'b00});
    // Second request on pin 1 with every source unmasked; first stays quiet
    apb(1, `GFC_IDX_IRQ_MASK2, 32'h0);
    apb(1, `GFC_IDX_PIN1_CFG, 32'h0003);
    repeat (3) @(posedge clk);
    chk({31'h0, irq_req_n, pin_out[1]}, {31'h0, 1'b1, |rv[9:0]});
    // Divided clocks on both pins from random ticks
    rv = $urandom;
    s0 = rv[1:0];
    s1 = rv[3:2];
    apb(1, `GFC_IDX_PIN0_CFG, 32'h0004);
    apb(1, `GFC_IDX_PIN1_CFG, 32'h003D);
    apb(1, `GFC_IDX_SYS_CLKOUT, {16'h0, 1'b1, 7'h0, rv[8:4], 1'b0, rv[1:0]});
    apb(1, `GFC_IDX_ASYNC_CLKOUT, {16'h0, 1'b1, 7'h0, rv[13:9], 1'b0, rv[3:2]});
    repeat (3) @(posedge clk);
    tk0 = 0;
    tk1 = 0;
    tg0 = 0;
    tg1 = 0;
    tick_on <= 1;
    repeat (400) @(posedge clk);
    tick_on <= 0;
    repeat (5) @(posedge clk);
    chk(tg0, tk0 / (rv[8:4] < 2 ? 1 : rv[8:4]));
    chk(tg1, tk1 / (rv[13:9] < 2 ? 1 : rv[13:9]));
    apb(1, `GFC_IDX_SYS_CLKOUT, {24'h0, rv[8:4], 1'b0, rv[1:0]});
    apb(1, `GFC_IDX_ASYNC_CLKOUT, {24'h0, rv[13:9], 1'b0, rv[3:2]});
    tick_on <= 1;
    repeat (40) @(posedge clk);
    chk({31'h0, pin_out}, 33'h0);
    // Reserved source code with the output enabled gives no clock
    apb(1, `GFC_IDX_SYS_CLKOUT, {16'h0, 1'b1, 12'h0, 1'b1, rv[1:0]});
    repeat (40) @(posedge clk);
    chk({32'h0, pin_out[0]}, 33'h0);
    tick_on <= 0;
    final_report;
  end
endmodule
